// *** logic/regfmt_pkg.sv ***
package regfmt_pkg;

    // Bus address is register number minus this offset
    localparam logic [15:0] reg_number_base   = 16'h0001;

    // Attribute bit positions within a map entry
    localparam int attr_read_pos     = 0;
    localparam int attr_write_pos    = 1;
    localparam int attr_oplock_pos   = 2;
    localparam int attr_cyclic_pos   = 3;
    localparam int attr_impl_pos     = 4;
    localparam int attr_width        = 5;

    // Data format codes
    typedef enum logic [3:0] {
        fmt_u16_int,
        fmt_u16_acc,
        fmt_u16_enum,
        fmt_u16_bits,
        fmt_pad,
        fmt_s16_int,
        fmt_sunssf,
        fmt_u32_int,
        fmt_u32_acc,
        fmt_s32_int,
        fmt_u64_acc,
        fmt_u64_int,
        fmt_string
    } fmt_t;

    // Not-implemented codes, padding value and range limits
    localparam logic [15:0] ni_all_ones  = 16'hFFFF;
    localparam logic [15:0] ni_zero      = 16'h0000;
    localparam logic [15:0] ni_signed    = 16'h8000;
    localparam logic [15:0] pad_value    = 16'h8000;
    localparam logic [15:0] zero_word    = 16'h0000;
    localparam logic [15:0] bits_limit   = 16'h7FFF;
    localparam logic [15:0] u16_limit    = 16'hFFFE;
    localparam logic [15:0] s16_low      = 16'h8001;
    localparam logic [15:0] ssf_high     = 16'h000A;
    localparam logic [15:0] ssf_low      = 16'hFFF6;

    // Local register store
    localparam int          store_depth  = 64;
    localparam int          store_aw     = 6;

    // Reset values
    localparam logic [15:0] store_reset  = 16'h0000;
    localparam logic [63:0] snap_reset   = 64'h0000_0000_0000_0000;

endpackage

// *** logic/word_store.sv ***
`timescale 1ns/1ps
// Register word memory; read data comes out of a register.
module word_store
(
    input  wire logic        core_clk,
    input  wire logic [5:0]  rd_addr,
    output logic      [15:0] rd_data,
    input  wire logic        wr_en,
    input  wire logic [5:0]  wr_addr,
    input  wire logic [15:0] wr_data
);

    logic [15:0] mem [regfmt_pkg::store_depth];

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        rd_data <= mem[rd_addr];
    end

endmodule // word_store

// *** logic/modbus_register_format_logic.sv ***
`timescale 1ns/1ps
// Operation
// - bus address equals one-based register number minus one.
// - writes need the writable attribute, reads of implemented registers need the readable one.
// - operating-locked registers drop writes while the power stage is on.
// - cyclic-safe registers take repeated writes without storage wear.
// - unsigned 16-bit value in one register, high byte first.
// - signed 16-bit range plus or minus 32767; absent returns 0x8000.
// - unsigned 32-bit spans two registers, high half first; absent returns all ones.
// - signed 32-bit spans two registers; absent returns 0x8000 0000.
// - 64-bit spans four registers high first; absent accumulator reads zero.
// - text fills register run, two chars each, first char high, zero padded.
// - absent text reads zero in every register.
// - reads of unimplemented registers succeed with the format's absent code.
// - padding registers always read 0x8000.
// - accumulators wrap monotonically; 16-bit counts to 65534, absent reads zero.
// - 16-bit bitfield uses 0 to 0x7FFF; absent reads 0xFFFF.
// - 16-bit enum or integer ranges to 65534; absent code 0xFFFF.
// - scale factor is signed exponent -10 to 10; 0x8000 means absent.
// - reply words go high byte first, right justified.
//
// The map is supplied by the surrounding logic per address: format, attributes,
// the word index within a multi-register value, and the live value of the
// whole parameter (up to 64 bits). Writes to store-backed registers go to a local word store.
module modbus_register_format_logic
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Request side
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_first,
    input  wire logic [15:0] req_reg_number,
    input  wire logic [15:0] req_wdata,
    // Map lookup for the requested register
    output logic      [15:0] map_addr,
    input  wire logic [3:0]  map_fmt,
    input  wire logic [4:0]  map_attr,
    input  wire logic [1:0]  map_word,
    input  wire logic        map_from_store,
    input  wire logic [5:0]  map_store_idx,
    input  wire logic [63:0] map_value,
    input  wire logic        power_on,
    // Answer side
    output logic             rsp_valid,
    output logic             rsp_ok,
    output logic      [7:0]  rsp_byte_hi,
    output logic      [7:0]  rsp_byte_lo,
    output logic             wr_accepted,
    output logic             wr_dropped_lock,
    output logic             wr_cyclic
);

    typedef enum logic [1:0] {
        st_idle,
        st_lookup,
        st_fetch,
        st_answer
    } state_t;

    state_t      state_reg;
    state_t      state_next;
    logic [15:0] addr_reg;
    logic        write_reg;
    logic        first_reg;
    logic [15:0] wdata_reg;
    logic [3:0]  fmt_reg;
    logic [4:0]  attr_reg;
    logic [1:0]  word_reg;
    logic        store_sel_reg;
    logic [5:0]  store_idx_reg;
    logic [63:0] snap_reg;
    logic [63:0] snap_next;
    logic [15:0] store_rdata;
    logic        store_we;
    logic [15:0] word_sel;
    logic [15:0] read_word;
    logic        impl;

    // Map address tracks the latched request
    assign map_addr = addr_reg;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_reg <= st_idle;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle:   if (req_valid) state_next = st_lookup;
            st_lookup: state_next = st_fetch;
            st_fetch:  state_next = st_answer;
            st_answer: state_next = st_idle;
        endcase
    end

    // Request capture
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            addr_reg  <= regfmt_pkg::store_reset;
            write_reg <= 1'b0;
            first_reg <= 1'b0;
            wdata_reg <= regfmt_pkg::store_reset;
        end
        else if (state_reg == st_idle && req_valid)
        begin
            addr_reg  <= req_reg_number - regfmt_pkg::reg_number_base;
            write_reg <= req_write;
            first_reg <= req_first;
            wdata_reg <= req_wdata;
        end
    end

    // Map capture
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            fmt_reg       <= 4'h0;
            attr_reg      <= 5'h00;
            word_reg      <= 2'h0;
            store_sel_reg <= 1'b0;
            store_idx_reg <= 6'h00;
        end
        else if (state_reg == st_lookup)
        begin
            fmt_reg       <= map_fmt;
            attr_reg      <= map_attr;
            word_reg      <= map_word;
            store_sel_reg <= map_from_store;
            store_idx_reg <= map_store_idx;
        end
    end

    // Whole value frozen at transaction start so halves never mix
    always_comb
    begin
        snap_next = snap_reg;
        if (state_reg == st_lookup && !write_reg && (first_reg || map_word == 2'd0))
        begin
            snap_next = map_value;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            snap_reg <= regfmt_pkg::snap_reset;
        end
        else
        begin
            snap_reg <= snap_next;
        end
    end

    assign impl = attr_reg[regfmt_pkg::attr_impl_pos];

    // Write gate: writable, and not locked while powered
    assign store_we = (state_reg == st_fetch) && write_reg && store_sel_reg
                      && attr_reg[regfmt_pkg::attr_write_pos]
                      && !(attr_reg[regfmt_pkg::attr_oplock_pos] && power_on);

    word_store u_store
    (
        .core_clk (core_clk),
        .rd_addr  (store_idx_reg),
        .rd_data  (store_rdata),
        .wr_en    (store_we),
        .wr_addr  (store_idx_reg),
        .wr_data  (wdata_reg)
    );

    // Big-endian word pick: word 0 is the most significant
    always_comb
    begin
        word_sel = snap_reg[15:0];
        unique case (regfmt_pkg::fmt_t'(fmt_reg))
            regfmt_pkg::fmt_u32_int,
            regfmt_pkg::fmt_u32_acc,
            regfmt_pkg::fmt_s32_int:
                word_sel = word_reg[0] ? snap_reg[15:0] : snap_reg[31:16];
            regfmt_pkg::fmt_u64_acc,
            regfmt_pkg::fmt_u64_int:
                unique case (word_reg)
                    2'd0: word_sel = snap_reg[63:48];
                    2'd1: word_sel = snap_reg[47:32];
                    2'd2: word_sel = snap_reg[31:16];
                    2'd3: word_sel = snap_reg[15:0];
                endcase
            default:
                word_sel = store_sel_reg ? store_rdata : snap_reg[15:0];
        endcase
    end

    // Format-dependent value or not-implemented code
    always_comb
    begin
        read_word = word_sel;
        unique case (regfmt_pkg::fmt_t'(fmt_reg))
            regfmt_pkg::fmt_pad:
                read_word = regfmt_pkg::pad_value;
            regfmt_pkg::fmt_u16_int,
            regfmt_pkg::fmt_u16_enum:
                if (!impl || word_sel > regfmt_pkg::u16_limit)
                    read_word = regfmt_pkg::ni_all_ones;
            regfmt_pkg::fmt_u16_bits:
                if (!impl || word_sel > regfmt_pkg::bits_limit)
                    read_word = regfmt_pkg::ni_all_ones;
            regfmt_pkg::fmt_u16_acc:
                if (!impl)
                    read_word = regfmt_pkg::ni_zero;
                else if (word_sel > regfmt_pkg::u16_limit)
                    read_word = word_sel - regfmt_pkg::u16_limit - 16'h0001;
            regfmt_pkg::fmt_s16_int:
                if (!impl || word_sel == regfmt_pkg::ni_signed)
                    read_word = regfmt_pkg::ni_signed;
            regfmt_pkg::fmt_sunssf:
                if (!impl || ($signed(word_sel) > $signed(regfmt_pkg::ssf_high))
                    || ($signed(word_sel) < $signed(regfmt_pkg::ssf_low)))
                    read_word = regfmt_pkg::ni_signed;
            regfmt_pkg::fmt_u32_int:
                if (!impl)
                    read_word = regfmt_pkg::ni_all_ones;
            regfmt_pkg::fmt_u64_int:
                if (!impl)
                    read_word = regfmt_pkg::ni_all_ones;
            regfmt_pkg::fmt_s32_int:
                if (!impl)
                    read_word = word_reg[0] ? regfmt_pkg::ni_zero
                                            : regfmt_pkg::ni_signed;
            regfmt_pkg::fmt_u32_acc,
            regfmt_pkg::fmt_u64_acc:
                if (!impl)
                    read_word = regfmt_pkg::ni_zero;
            regfmt_pkg::fmt_string:
                if (!impl)
                    read_word = regfmt_pkg::zero_word;
            default:
                read_word = regfmt_pkg::ni_all_ones;
        endcase
    end

    // Answer registers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rsp_valid   <= 1'b0;
            rsp_ok      <= 1'b0;
            rsp_byte_hi <= 8'h00;
            rsp_byte_lo <= 8'h00;
        end
        else
        begin
            rsp_valid <= (state_reg == st_answer);
            if (state_reg == st_answer)
            begin
                if (write_reg)
                begin
                    rsp_ok      <= attr_reg[regfmt_pkg::attr_write_pos];
                    rsp_byte_hi <= wdata_reg[15:8];
                    rsp_byte_lo <= wdata_reg[7:0];
                end
                else
                begin
                    // Unimplemented registers still answer with success
                    rsp_ok      <= attr_reg[regfmt_pkg::attr_read_pos] || !impl;
                    rsp_byte_hi <= read_word[15:8];
                    rsp_byte_lo <= read_word[7:0];
                end
            end
        end
    end

    // Write outcome flags, one-cycle pulses
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wr_accepted     <= 1'b0;
            wr_dropped_lock <= 1'b0;
            wr_cyclic       <= 1'b0;
        end
        else
        begin
            wr_accepted     <= store_we;
            wr_dropped_lock <= (state_reg == st_fetch) && write_reg
                               && attr_reg[regfmt_pkg::attr_write_pos]
                               && attr_reg[regfmt_pkg::attr_oplock_pos] && power_on;
            // Cyclic-safe writes bypass nonvolatile commit; others signal a commit
            wr_cyclic       <= store_we && attr_reg[regfmt_pkg::attr_cyclic_pos];
        end
    end

endmodule // modbus_register_format_logic

// *** sim/regfmt_checker_assertions.sv ***
`timescale 1ns/1ps
module regfmt_checker
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [15:0] req_reg_number,
    input wire logic [15:0] map_addr,
    input wire logic [3:0]  map_fmt,
    input wire logic [4:0]  map_attr,
    input wire logic        power_on,
    input wire logic        rsp_valid,
    input wire logic        rsp_ok,
    input wire logic [7:0]  rsp_byte_hi,
    input wire logic [7:0]  rsp_byte_lo,
    input wire logic        wr_accepted,
    input wire logic        wr_dropped_lock,
    input wire logic        wr_cyclic
);
    logic [1:0] busy_reg;
    logic       take;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Mirrors the three busy cycles so that refused strobes are not counted
    assign take = req_valid && busy_reg == 2'h0;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            busy_reg <= 2'h0;
        else if (take)
            busy_reg <= 2'h3;
        else if (busy_reg != 2'h0)
            busy_reg <= busy_reg - 2'h1;
    end

    a_addr_offset: assert property (take |=>
        map_addr == $past(req_reg_number) - regfmt_pkg::reg_number_base)
        else $error("bus address is not register number minus one");
    a_answer_time: assert property (take |-> ##4 rsp_valid)
        else $error("answer missing four cycles after request");
    a_answer_cause: assert property (rsp_valid |-> $past(take, 4))
        else $error("answer without a request");
    a_write_refused: assert property (take && req_write ##2
        !map_attr[regfmt_pkg::attr_write_pos] |-> ##1 !wr_accepted ##1 rsp_valid && !rsp_ok)
        else $error("write to non-writable register not refused");
    a_lock_drop: assert property (take && req_write ##2 (power_on
        && map_attr[regfmt_pkg::attr_write_pos] && map_attr[regfmt_pkg::attr_oplock_pos])
        |-> ##1 wr_dropped_lock && !wr_accepted ##1 rsp_valid && rsp_ok)
        else $error("locked write not dropped while powered");
    a_cyclic_flag: assert property (wr_cyclic |->
        wr_accepted && map_attr[regfmt_pkg::attr_cyclic_pos])
        else $error("cyclic flag without accepted cyclic write");
    a_pad_value: assert property (take && !req_write ##2
        map_fmt == regfmt_pkg::fmt_pad |-> ##2 rsp_valid
        && {rsp_byte_hi, rsp_byte_lo} == regfmt_pkg::pad_value)
        else $error("padding register read wrong");
    a_s16_absent: assert property (take && !req_write ##2
        (map_fmt == regfmt_pkg::fmt_s16_int && !map_attr[regfmt_pkg::attr_impl_pos])
        |-> ##2 rsp_valid && {rsp_byte_hi, rsp_byte_lo} == regfmt_pkg::ni_signed)
        else $error("absent signed value read wrong");
endmodule // regfmt_checker

bind modbus_register_format_logic regfmt_checker u_checker
(
    .core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
    .req_reg_number(req_reg_number), .map_addr(map_addr), .map_fmt(map_fmt),
    .map_attr(map_attr), .power_on(power_on), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_byte_hi(rsp_byte_hi), .rsp_byte_lo(rsp_byte_lo), .wr_accepted(wr_accepted),
    .wr_dropped_lock(wr_dropped_lock), .wr_cyclic(wr_cyclic)
);

// *** sim/bus_master_model.sv ***
`timescale 1ns/1ps
module bus_master_model
(
    input  wire logic        core_clk,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_ok,
    input  wire logic [7:0]  rsp_byte_hi,
    input  wire logic [7:0]  rsp_byte_lo,
    input  wire logic        wr_accepted,
    input  wire logic        wr_dropped_lock,
    input  wire logic        wr_cyclic,
    output logic             req_valid,
    output logic             req_write,
    output logic             req_first,
    output logic      [15:0] req_reg_number,
    output logic      [15:0] req_wdata
);
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_first = 1'b0;
        req_reg_number = 16'h0000;
        req_wdata = 16'h0000;
    end

    task automatic access(input logic wr, input logic first, input logic [15:0] num,
        input logic [15:0] wd, output logic ok, output logic [15:0] word,
        output logic [2:0] flags, output logic tmo);
        flags = 3'h0;
        tmo = 1'b1;
        ok = 1'b0;
        word = 16'h0000;
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_first = first;
        req_reg_number = num;
        req_wdata = wd;
        @(posedge core_clk);
        #1;
        // Released lines flip so a stale number can never pass for a live one
        req_valid = 1'b0;
        req_reg_number = ~num;
        req_wdata = ~wd;
        for (int i = 0; i < 8 && tmo; i++)
        begin
            @(posedge core_clk);
            #1;
            flags = flags | {wr_accepted, wr_dropped_lock, wr_cyclic};
            if (rsp_valid)
            begin
                tmo = 1'b0;
                ok = rsp_ok;
                word = {rsp_byte_hi, rsp_byte_lo};
            end
        end
    endtask
endmodule // bus_master_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        regfmt_pkg::fmt_t fmt;
        logic [4:0]       attr;
        logic [1:0]       word;
        logic [63:0]      value;
        logic [15:0]      exp_word;
    } row_t;
    logic        core_clk, resetn, power_on, req_valid, req_write, req_first, rsp_valid;
    logic        rsp_ok, wr_accepted, wr_dropped_lock, wr_cyclic, from_store, ok;
    logic [15:0] req_reg_number, req_wdata, map_addr, k, rd;
    logic [7:0]  rsp_byte_hi, rsp_byte_lo;
    logic [63:0] bump;
    logic [2:0]  fl;
    int          fail_count = 0;
    int          compares = 0;
    logic [4:0]  st_attr [4] = '{5'h13, 5'h17, 5'h11, 5'h1B};
    row_t        rows [20] = '{
        '{regfmt_pkg::fmt_u32_int, 5'h11, 2'h0, 64'hA1B2_C3D4, 16'hA1B2},
        '{regfmt_pkg::fmt_u32_int, 5'h11, 2'h1, 64'hA1B2_C3D4, 16'hC3D4},
        '{regfmt_pkg::fmt_u32_int, 5'h01, 2'h1, 64'h0, 16'hFFFF},
        '{regfmt_pkg::fmt_s32_int, 5'h01, 2'h0, 64'h0, 16'h8000},
        '{regfmt_pkg::fmt_s32_int, 5'h01, 2'h1, 64'h0, 16'h0000},
        '{regfmt_pkg::fmt_u64_acc, 5'h11, 2'h0, 64'h0102_0304_0506_0708, 16'h0102},
        '{regfmt_pkg::fmt_u64_acc, 5'h11, 2'h3, 64'h0102_0304_0506_0708, 16'h0708},
        '{regfmt_pkg::fmt_u64_acc, 5'h01, 2'h2, 64'h0, 16'h0000},
        '{regfmt_pkg::fmt_pad, 5'h01, 2'h0, 64'h0, 16'h8000},
        '{regfmt_pkg::fmt_u16_int, 5'h00, 2'h0, 64'h0, 16'hFFFF},
        '{regfmt_pkg::fmt_u16_acc, 5'h01, 2'h0, 64'h0, 16'h0000},
        '{regfmt_pkg::fmt_u16_enum, 5'h01, 2'h0, 64'h0, 16'hFFFF},
        '{regfmt_pkg::fmt_u16_bits, 5'h01, 2'h0, 64'h0, 16'hFFFF},
        '{regfmt_pkg::fmt_s16_int, 5'h01, 2'h0, 64'h0, 16'h8000},
        '{regfmt_pkg::fmt_sunssf, 5'h01, 2'h0, 64'h0, 16'h8000},
        '{regfmt_pkg::fmt_sunssf, 5'h11, 2'h0, 64'hFFF6, 16'hFFF6},
        '{regfmt_pkg::fmt_string, 5'h01, 2'h0, 64'h0, 16'h0000},
        '{regfmt_pkg::fmt_u16_int, 5'h11, 2'h0, 64'h1234, 16'h1234},
        '{regfmt_pkg::fmt_string, 5'h11, 2'h0, 64'h4142, 16'h4142},
        '{regfmt_pkg::fmt_u16_int, 5'h10, 2'h0, 64'h1234, 16'h1234}};

    // Entries 20 to 23 past the table base are store-backed single words
    assign k = map_addr - 16'h9C40;
    assign from_store = k >= 16'h0014 && k <= 16'h0017;

    modbus_register_format_logic dut (.core_clk(core_clk), .resetn(resetn),
        .req_valid(req_valid), .req_write(req_write), .req_first(req_first),
        .req_reg_number(req_reg_number), .req_wdata(req_wdata), .map_addr(map_addr),
        .map_fmt(from_store ? 4'(regfmt_pkg::fmt_u16_int) : rows[k].fmt),
        .map_attr(from_store ? st_attr[k[1:0]] : rows[k].attr), .map_word(rows[k].word),
        .map_from_store(from_store), .map_store_idx(k[5:0]),
        .map_value(rows[k].value ^ bump), .power_on(power_on), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_byte_hi(rsp_byte_hi), .rsp_byte_lo(rsp_byte_lo),
        .wr_accepted(wr_accepted), .wr_dropped_lock(wr_dropped_lock), .wr_cyclic(wr_cyclic));
    bus_master_model u_master (.core_clk(core_clk), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_byte_hi(rsp_byte_hi), .rsp_byte_lo(rsp_byte_lo), .wr_accepted(wr_accepted),
        .wr_dropped_lock(wr_dropped_lock), .wr_cyclic(wr_cyclic), .req_valid(req_valid),
        .req_write(req_write), .req_first(req_first), .req_reg_number(req_reg_number),
        .req_wdata(req_wdata));

    task automatic finish_test();
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic checkw(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic checkf(input logic [3:0] got, input logic [3:0] exp);
        checkw({12'h000, got}, {12'h000, exp});
    endtask

    task automatic xfer(input logic wr, input logic first, input logic [15:0] num,
        input logic [15:0] wd);
        logic tmo;
        u_master.access(wr, first, num, wd, ok, rd, fl, tmo);
        if (tmo)
        begin
            fail_count++;
            finish_test();
        end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial
    begin
        resetn = 1'b0;
        power_on = 1'b0;
        bump = 64'h0;
        repeat (6) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 19; i++)
        begin
            xfer(1'b0, rows[i].word == 2'h0, 16'h9C41 + 16'(i), 16'h0000);
            checkw(rd, rows[i].exp_word);
            checkf({ok, fl}, 4'h8);
        end
        // Live value changes between words; the last word (word 3) must come from the snapshot
        xfer(1'b0, 1'b1, 16'h9C46, 16'h0000);
        bump = 64'hFFFF_FFFF_FFFF_FFFF;
        xfer(1'b0, 1'b0, 16'h9C47, 16'h0000);
        checkw(rd, 16'h0708);
        bump = 64'h0;
        // Writable non-cyclic registers take one write each; the locked one gets a second, dropped while powered; the unwritable one refuses its write
        xfer(1'b1, 1'b1, 16'h9C55, 16'h1357);
        checkf({ok, fl}, 4'hC);
        xfer(1'b0, 1'b1, 16'h9C55, 16'h0000);
        checkw(rd, 16'h1357);
        xfer(1'b1, 1'b1, 16'h9C56, 16'h2468);
        power_on = 1'b1;
        xfer(1'b1, 1'b1, 16'h9C56, 16'hFFFF);
        checkf({ok, fl}, 4'hA);
        xfer(1'b0, 1'b1, 16'h9C56, 16'h0000);
        checkw(rd, 16'h2468);
        power_on = 1'b0;
        xfer(1'b1, 1'b1, 16'h9C57, 16'h5555);
        checkf({ok, fl}, 4'h0);
        for (int i = 0; i < 2; i++)
        begin
            xfer(1'b1, 1'b1, 16'h9C58, 16'(i));
            checkf({ok, fl}, 4'hD);
        end
        // Implemented but unreadable register refuses the read
        xfer(1'b0, 1'b1, 16'h9C54, 16'h0000);
        checkf({ok, fl}, 4'h0);
        resetn = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        checkw(map_addr, 16'h0000);
        checkw({rsp_byte_hi, rsp_byte_lo}, 16'h0000);
        checkf({rsp_ok, wr_accepted, wr_dropped_lock, wr_cyclic}, 4'h0);
        resetn = 1'b1;
        xfer(1'b0, 1'b1, 16'h9C52, 16'h0000);
        checkw(rd, 16'h1234);
        finish_test();
    end
endmodule // testbench
